// >>> rtl/pcglp_defines.vh
`ifndef PCGLP_DEFINES_VH
`define PCGLP_DEFINES_VH
`define PCGLP_ADDR_SET      12'h000
`define PCGLP_ADDR_CLR      12'h004
`define PCGLP_ADDR_HIGH     12'h008
`define PCGLP_ADDR_LOW      12'h00C
`define PCGLP_ADDR_LPC      12'h010
`define PCGLP_ADDR_WAKE     12'h014
`define PCGLP_ADDR_STAT     12'h018
`define PCGLP_RST_HIGH      32'hFFFC00D0
`define PCGLP_RST_LOW       32'h00000300
`define PCGLP_RST_LPC       8'h00
`define PCGLP_RST_WAKE      3'h0
`define PCGLP_ALL_BIT       6
`define PCGLP_FAST_BIT      5
`define PCGLP_STPSEL_HI     4
`define PCGLP_STPSEL_LO     3
`define PCGLP_LPC_MASK      8'h38
`define PCGLP_SLOT_MASK     64'h0003_FF2F_F7EE_B004
`endif

// >>> rtl/pcglp_ctrl.v
`include "pcglp_defines.vh"

module pcglp_ctrl (
    // apb
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // power sequencing inputs (external domain)
    input  wire        stop_req_pin,
    input  wire        pll_lock_pin,
    input  wire        limp_mode_pin,
    input  wire [2:0]  irq_level_pin,
    // clock controls and wake request
    output reg  [63:0] slot_clock_run,
    output reg         sys_clock_run,
    output reg         bus_clock_out_en,
    output reg         pll_en,
    output reg         osc_en,
    output reg         wake_req
);
    ////////////////////////////////////////////////////////////////////////////////
    reg  [31:0] clock_gate_high_ff;
    reg  [31:0] clock_gate_low_ff;
    reg  [7:0]  low_power_control_ff;
    reg  [2:0]  wake_priority_threshold_ff;
    reg  [31:0] nxt_high;
    reg  [31:0] nxt_low;
    reg  [3:0]  sync1_ff;
    reg  [3:0]  sync2_ff;
    reg  [2:0]  irq1_ff;
    reg  [2:0]  irq2_ff;
    reg         stopped_ff;
    reg         stop_prev_ff;
    reg         fast_ff;
    reg         wait_lock_ff;
    reg  [1:0]  stop_sel_ff;
    wire        wr_en;
    wire        rd_en;
    wire        addr_ok;
    wire        stop_s;
    wire        lock_s;
    wire        limp_s;
    wire [63:0] gate_bits;
    wire [63:0] slot_bit;
    wire        irq_ok;

    // admitted when level exceeds threshold; 11x needs level 7
    function level_ok;
        input [2:0] thr;
        input [2:0] lvl;
        begin
            if (thr == 3'h0)
                level_ok = (lvl != 3'h0);
            else if (thr[2:1] == 2'h3)
                level_ok = (lvl == 3'h7);
            else
                level_ok = (lvl > thr);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    assign pready  = 1'b1;
    assign addr_ok = (paddr == `PCGLP_ADDR_SET) || (paddr == `PCGLP_ADDR_CLR) ||
                     (paddr == `PCGLP_ADDR_HIGH) || (paddr == `PCGLP_ADDR_LOW) ||
                     (paddr == `PCGLP_ADDR_LPC) || (paddr == `PCGLP_ADDR_WAKE) ||
                     (paddr == `PCGLP_ADDR_STAT);
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_en   = pce & psel & penable & pwrite & addr_ok;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign slot_bit = 64'h1 << pwdata[5:0];

    always @* begin
        nxt_high = clock_gate_high_ff;
        nxt_low  = clock_gate_low_ff;
        if (wr_en) begin
            case (paddr)
                `PCGLP_ADDR_HIGH: nxt_high = pwdata;
                `PCGLP_ADDR_LOW:  nxt_low  = pwdata;
                `PCGLP_ADDR_SET: begin
                    if (pwdata[`PCGLP_ALL_BIT]) begin
                        nxt_high = 32'hFFFFFFFF;
                        nxt_low  = 32'hFFFFFFFF;
                    end else begin
                        nxt_high = clock_gate_high_ff | slot_bit[63:32];
                        nxt_low  = clock_gate_low_ff | slot_bit[31:0];
                    end
                end
                `PCGLP_ADDR_CLR: begin
                    if (pwdata[`PCGLP_ALL_BIT]) begin
                        nxt_high = 32'h00000000;
                        nxt_low  = 32'h00000000;
                    end else begin
                        nxt_high = clock_gate_high_ff & ~slot_bit[63:32];
                        nxt_low  = clock_gate_low_ff & ~slot_bit[31:0];
                    end
                end
                default: begin
                    nxt_high = clock_gate_high_ff;
                    nxt_low  = clock_gate_low_ff;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_gate_high_ff         <= `PCGLP_RST_HIGH;
            clock_gate_low_ff          <= `PCGLP_RST_LOW;
            low_power_control_ff       <= `PCGLP_RST_LPC;
            wake_priority_threshold_ff <= `PCGLP_RST_WAKE;
        end else if (pce) begin
            clock_gate_high_ff <= nxt_high;
            clock_gate_low_ff  <= nxt_low;
            if (wr_en && paddr == `PCGLP_ADDR_LPC)
                low_power_control_ff <= pwdata[7:0] & `PCGLP_LPC_MASK;
            if (wr_en && paddr == `PCGLP_ADDR_WAKE)
                wake_priority_threshold_ff <= pwdata[2:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (pce && rd_en) begin
            case (paddr)
                `PCGLP_ADDR_HIGH: prdata <= clock_gate_high_ff;
                `PCGLP_ADDR_LOW:  prdata <= clock_gate_low_ff;
                `PCGLP_ADDR_LPC:  prdata <= {24'h000000, low_power_control_ff};
                `PCGLP_ADDR_WAKE: prdata <= {29'h00000000, wake_priority_threshold_ff};
                `PCGLP_ADDR_STAT: prdata <= {28'h0000000, wait_lock_ff, stopped_ff,
                                             lock_s, limp_s};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            irq1_ff  <= 3'h0;
            irq2_ff  <= 3'h0;
        end else if (pce) begin
            sync1_ff <= {stop_req_pin, pll_lock_pin, limp_mode_pin, 1'b0};
            sync2_ff <= sync1_ff;
            irq1_ff  <= irq_level_pin;
            irq2_ff  <= irq1_ff;
        end
    end
    assign stop_s = sync2_ff[3];
    assign lock_s = sync2_ff[2];
    assign limp_s = sync2_ff[1];
    assign irq_ok = level_ok(wake_priority_threshold_ff, irq2_ff);

    // stop entry / wake sequencing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stopped_ff   <= 1'b0;
            stop_prev_ff <= 1'b0;
            fast_ff      <= 1'b0;
            wait_lock_ff <= 1'b0;
            stop_sel_ff  <= 2'h0;
        end else if (pce) begin
            stop_prev_ff <= stop_s;
            // enter only on a new stop request, so a held request cannot re-stop after wake
            if (!stopped_ff && !wait_lock_ff && stop_s && !stop_prev_ff) begin
                stopped_ff  <= 1'b1;
                fast_ff     <= low_power_control_ff[`PCGLP_FAST_BIT];
                stop_sel_ff <= low_power_control_ff[`PCGLP_STPSEL_HI:`PCGLP_STPSEL_LO];
            end else if (stopped_ff && irq_ok) begin
                stopped_ff <= 1'b0;
                // limp or fast wake restart at once, else wait for lock
                wait_lock_ff <= ~(fast_ff | limp_s);
            end else if (wait_lock_ff && (lock_s || limp_s)) begin
                wait_lock_ff <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unassigned slots and ungated modules never stop
    assign gate_bits = {clock_gate_high_ff, clock_gate_low_ff} & `PCGLP_SLOT_MASK;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_clock_run   <= 64'hFFFFFFFFFFFFFFFF;
            sys_clock_run    <= 1'b1;
            bus_clock_out_en <= 1'b1;
            pll_en           <= 1'b1;
            osc_en           <= 1'b1;
            wake_req         <= 1'b0;
        end else if (pce) begin
            slot_clock_run   <= ~gate_bits;
            sys_clock_run    <= ~stopped_ff & ~wait_lock_ff;
            bus_clock_out_en <= ~(stopped_ff & (stop_sel_ff != 2'h0));
            pll_en           <= ~(stopped_ff & stop_sel_ff[1]);
            osc_en           <= ~(stopped_ff & (stop_sel_ff == 2'h3));
            wake_req         <= stopped_ff & irq_ok;
        end
    end

endmodule

// >>> tb/pcglp_ctrl_asserts.sv
`include "pcglp_defines.vh"
module pcglp_ctrl_asserts (
    // apb
    input logic        pclk,
    input logic        presetn,
    input logic        pce,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    // power
    input logic        stop_req_pin,
    input logic [2:0]  irq_level_pin,
    input logic [63:0] slot_clock_run,
    input logic        sys_clock_run
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pce && pwrite;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h018);
    ready_always_a: assert property (psel && penable |-> pready) else $error("ready low");
    err_unmapped_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped");
    err_only_bad_a: assert property (pslverr |-> psel && penable && !mapped)
        else $error("spurious error");
    wo_read_zero_a: assert property (psel && !penable && !pwrite && pce && paddr[11:3] == 9'h0
        |=> prdata == 32'h0) else $error("write-only read nonzero");
    fixed_slots_a: assert property ((slot_clock_run | `PCGLP_SLOT_MASK) == {64{1'b1}})
        else $error("fixed slot gated");
    set_all_a: assert property (acc && paddr == 12'h000 && pwdata[6]
        |-> ##2 (slot_clock_run & `PCGLP_SLOT_MASK) == 64'h0) else $error("set all missed");
    clear_all_a: assert property (acc && paddr == 12'h004 && pwdata[6]
        |-> ##2 slot_clock_run == {64{1'b1}}) else $error("clear all missed");
    stop_halt_a: assert property ($rose(stop_req_pin) ##1
        (stop_req_pin && irq_level_pin == 3'h0)[*6]
        |-> !sys_clock_run) else $error("clock runs in stop");
endmodule
bind pcglp_ctrl pcglp_ctrl_asserts u_chk (.*);

// >>> tb/pcglp_ctrl_tb_top.sv
`include "pcglp_defines.vh"
module pcglp_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0;
    logic        stop_req_pin = 0, pll_lock_pin = 1, limp_mode_pin = 0, err;
    logic        pready, pslverr, sys_clock_run, bus_clock_out_en, pll_en, osc_en, wake_req;
    logic [2:0]  irq_level_pin = 3'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [63:0] slot_clock_run, msk = `PCGLP_SLOT_MASK;
    int          n_mismatch = 0, comparisons = 0, wake_cnt = 0, w0;
    always #25 pclk = ~pclk;
    always @(posedge pclk)
        if (wake_req === 1'b1) wake_cnt <= wake_cnt + 1;
    pcglp_ctrl u_dut (.*);
    task chk(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(0, a, 32'h0);
        chk(rd, e);
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(10);
        presetn <= 1;
        rdchk(`PCGLP_ADDR_HIGH, `PCGLP_RST_HIGH);
        rdchk(`PCGLP_ADDR_LOW, `PCGLP_RST_LOW);
        chk(slot_clock_run, ~({`PCGLP_RST_HIGH, `PCGLP_RST_LOW} & msk));
        xfer(1, `PCGLP_ADDR_SET, 32'h21);
        xfer(1, `PCGLP_ADDR_CLR, 32'h89);
        tick(2);
        chk({slot_clock_run[33], slot_clock_run[9]}, 2'b01);
        rdchk(`PCGLP_ADDR_HIGH, `PCGLP_RST_HIGH | 32'h2);
        rdchk(`PCGLP_ADDR_LOW, 32'h100);
        rdchk(`PCGLP_ADDR_SET, 32'h0);
        rdchk(`PCGLP_ADDR_CLR, 32'h0);
        xfer(1, `PCGLP_ADDR_SET, 32'h40);
        tick(2);
        chk(slot_clock_run, ~msk);
        rdchk(`PCGLP_ADDR_LOW, 32'hFFFFFFFF);
        xfer(1, `PCGLP_ADDR_CLR, 32'h7F);
        rdchk(`PCGLP_ADDR_HIGH, 32'h0);
        xfer(1, `PCGLP_ADDR_LOW, 32'hA5A50000);
        rdchk(`PCGLP_ADDR_LOW, 32'hA5A50000);
        rdchk(12'h020, 32'h0);
        chk(err, 1'b1);
        xfer(1, `PCGLP_ADDR_LPC, 32'hFF);
        rdchk(`PCGLP_ADDR_LPC, 32'h38);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            xfer(1, `PCGLP_ADDR_LPC, 32'(s << 3));
            stop_req_pin <= 1;
            tick(7);
            chk({sys_clock_run, bus_clock_out_en, pll_en, osc_en},
                {1'b0, s == 0, s < 2, s < 3});
            stop_req_pin <= 0;
            irq_level_pin <= 3'h7;
            tick(6);
            irq_level_pin <= 3'h0;
            tick(6);
        end
        $display("test stop select done");
        for (int t = 0; t < 8; t++) begin
            xfer(1, `PCGLP_ADDR_WAKE, 32'(t));
            for (int l = 1; l < 8; l++) begin
                w0 = wake_cnt;
                irq_level_pin <= 3'(l);
                stop_req_pin <= 1;
                tick(8);
                chk(wake_cnt != w0, l > (t > 5 ? 6 : t));
                rdchk(`PCGLP_ADDR_STAT, l > (t > 5 ? 6 : t) ? 32'h2 : 32'h6);
                irq_level_pin <= 3'h7;
                stop_req_pin <= 0;
                tick(6);
                irq_level_pin <= 3'h0;
                tick(6);
            end
        end
        $display("test threshold done");
        for (int k = 0; k < 3; k++) begin
            xfer(1, `PCGLP_ADDR_LPC, k == 1 ? 32'h20 : 32'h0);
            limp_mode_pin <= (k == 2);
            pll_lock_pin <= 0;
            stop_req_pin <= 1;
            tick(7);
            irq_level_pin <= 3'h7;
            tick(6);
            stop_req_pin <= 0;
            irq_level_pin <= 3'h0;
            tick(6);
            chk(sys_clock_run, k != 0);
            pll_lock_pin <= 1;
            tick(6);
            chk(sys_clock_run, 1'b1);
        end
        $display("test wake done");
        final_report;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        final_report;
    end
endmodule
